// ==== hdl/arsc_consts.svh ====
// constants for the read-sectors command block
`ifndef ARSC_CONSTS_SVH
`define ARSC_CONSTS_SVH
// register offsets on the plain register port
`define ARSC_OFF_DATA 4'h0
`define ARSC_OFF_FEAT 4'h1
`define ARSC_OFF_SCNT 4'h2
`define ARSC_OFF_SNUM 4'h3
`define ARSC_OFF_CLO 4'h4
`define ARSC_OFF_CHI 4'h5
`define ARSC_OFF_DEVH 4'h6
`define ARSC_OFF_CMD 4'h7
`define ARSC_OFF_ERR 4'h8
`define ARSC_OFF_DCTL 4'h9
`define ARSC_OFF_ISTS 4'hA
`define ARSC_OFF_IMSK 4'hB
// opcodes; bit 0 of the 28-bit opcode is the retry bit
`define ARSC_OP_RD28 8'h20
`define ARSC_OP_RD28_MASK 8'hFE
`define ARSC_OP_RD48 8'h24
// field positions
`define ARSC_DH_LBA 6
`define ARSC_DCTL_HOB 7
`define ARSC_ERR_UNC 6
`define ARSC_ERR_IDN 4
`define ARSC_ERR_ABT 2
`define ARSC_IRQ_DONE 0
`define ARSC_IRQ_ERR 1
`define ARSC_IRQ_DRQ 2
// reset values and counts
`define ARSC_DEVH_RST 8'hA0
`define ARSC_BYTE_RST 8'h01
`define ARSC_CNT28_ZERO 17'h00100
`define ARSC_CNT48_ZERO 17'h10000
`define ARSC_WORDS_LAST 8'hFF
`endif

// ==== hdl/arsc_pkg.sv ====
// types shared by the read-sectors command block
package arsc_pkg;
	// register port request from software
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [15:0] wdata;
	} arsc_reg_req_t;
	// sector fetch request to the media side
	typedef struct packed {
		logic start;
		logic chs;
		logic [47:0] addr;
	} arsc_media_req_t;
	// one word, or an error, back from the media side
	typedef struct packed {
		logic valid;
		logic unc;
		logic idnf;
		logic [15:0] data;
	} arsc_media_rsp_t;
	typedef enum logic [1:0] {
		ARSC_ST_IDLE = 2'b00,
		ARSC_ST_REQ = 2'b01,
		ARSC_ST_XFER = 2'b10
	} arsc_state_t;
endpackage : arsc_pkg

// ==== hdl/arsc_read_cmd.sv ====
// read-sectors command interpreter with task file, data port and interrupt
// Notes on behaviour
// - opcodes 20h and 21h both start the same 28-bit read.
// - a 28-bit count of zero means 256 sectors.
// - sector number is the start sector in CHS, address bits 7:0 in LBA.
// - cylinder low/high give the cylinder in CHS, address bits 8-23 in LBA.
// - the head field gives the head in CHS, address bits 24-27 in LBA.
// - the retry bit of the opcode is ignored.
// - at the end a 28-bit read leaves the sectors not moved in the sector count; a 48-bit read leaves the count as written.
// - at the end the address registers hold the last sector handled.
// - opcode 24h starts a 48-bit read of 1 to 65536 sectors.
// - sector data leaves through the data register one 16-bit word at a time.
// - an uncorrectable error ends the read at the failing sector.
// - the 48-bit count is previous byte high, current byte low.
// - a 48-bit count of zero means 65536 sectors.
// - the 48-bit address bytes come from current/previous, read back by HOB.
// - ending status shows busy clear, ready and seek done, only UNC/IDN/ABT errors.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "arsc_consts.svh"
module arsc_read_cmd #(
	parameter int SECT_PER_TRK = 63,
	parameter int HEADS = 16
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire arsc_pkg::arsc_reg_req_t reg_req_i,
	output logic [15:0] reg_rdata_o,
	output arsc_pkg::arsc_media_req_t media_req_o,
	output logic media_rdy_o,
	input wire arsc_pkg::arsc_media_rsp_t media_rsp_i,
	output logic busy_o,
	output logic irq_o
);
	import arsc_pkg::*;

	// current and previous byte of each address/count register
	logic [7:0] scnt_r;
	logic [7:0] scnt_p_r;
	logic [7:0] snum_r;
	logic [7:0] snum_p_r;
	logic [7:0] clo_r;
	logic [7:0] clo_p_r;
	logic [7:0] chi_r;
	logic [7:0] chi_p_r;
	logic [7:0] devh_r;
	logic hob_r;
	logic [7:0] err_r;
	logic err_flag_r;
	logic [2:0] ists_r;
	logic [2:0] imsk_r;
	logic [15:0] data_r;
	logic drq_r;
	logic busy_r;
	logic ext_r;
	logic chs_r;
	logic [47:0] addr_r;
	logic [16:0] remain_r;
	logic [7:0] word_r;
	logic start_r;
	arsc_state_t state_r;

	logic wr_ok;
	logic cmd_wr;
	logic op28;
	logic op48;
	logic data_rd;
	logic sect_end;
	logic last_sect;
	logic rsp_word;
	logic rsp_err;
	logic finish_ok;
	logic finish_err;
	logic cmd_abort;
	logic [7:0] status;

	// pick current or previous byte for readback
	function automatic logic [7:0] tf_sel(input logic [7:0] cur, input logic [7:0] prev,
			input logic hob);
		tf_sel = hob ? prev : cur;
	endfunction : tf_sel

	// next sector address; CHS packs head, cylinder, sector as loaded and written back
	function automatic logic [47:0] next_addr(input logic [47:0] a, input logic chs);
		logic [15:0] cyl;
		logic [3:0] hd;
		logic [7:0] sc;
		cyl = a[23:8];
		hd = a[27:24];
		sc = a[7:0];
		if (!chs) begin
			next_addr = a + 48'h000000000001;
		end else begin
			if (sc == 8'(SECT_PER_TRK)) begin
				sc = 8'h01;
				if (hd == 4'(HEADS - 1)) begin
					hd = 4'h0;
					cyl = cyl + 16'h0001;
				end else begin
					hd = hd + 4'h1;
				end
			end else begin
				sc = sc + 8'h01;
			end
			next_addr = {20'h00000, hd, cyl, sc};
		end
	endfunction : next_addr

	// task file is only writable while idle; no command queueing
	assign wr_ok = reg_req_i.wr && !busy_r;
	assign cmd_wr = wr_ok && (reg_req_i.addr == `ARSC_OFF_CMD);
	// opcode decode ignores retry bit
	// retry ignored
	assign op28 = (reg_req_i.wdata[7:0] & `ARSC_OP_RD28_MASK) == `ARSC_OP_RD28;
	assign op48 = reg_req_i.wdata[7:0] == `ARSC_OP_RD48;
	assign cmd_abort = cmd_wr && !op28 && !op48;
	assign data_rd = reg_req_i.rd && (reg_req_i.addr == `ARSC_OFF_DATA) && drq_r;
	assign sect_end = data_rd && (word_r == `ARSC_WORDS_LAST);
	assign last_sect = remain_r == 17'h00001;
	assign rsp_word = (state_r == ARSC_ST_XFER) && !drq_r && media_rsp_i.valid
		&& !media_rsp_i.unc && !media_rsp_i.idnf;
	assign rsp_err = (state_r == ARSC_ST_XFER) && !drq_r && media_rsp_i.valid
		&& (media_rsp_i.unc || media_rsp_i.idnf);
	assign finish_ok = sect_end && last_sect;
	assign finish_err = rsp_err;

	// command state and sector bookkeeping
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= ARSC_ST_IDLE;
			busy_r <= 1'b0;
			ext_r <= 1'b0;
			chs_r <= 1'b0;
			addr_r <= 48'h000000000000;
			remain_r <= 17'h00000;
			start_r <= 1'b0;
		end else begin
			start_r <= 1'b0;
			case (state_r)
				ARSC_ST_IDLE: begin
					if (cmd_wr && op28) begin
						busy_r <= 1'b1;
						ext_r <= 1'b0;
						chs_r <= !devh_r[`ARSC_DH_LBA];
						remain_r <= (scnt_r == 8'h00) ? `ARSC_CNT28_ZERO : {9'h000, scnt_r};
						addr_r <= {20'h00000, devh_r[3:0], chi_r, clo_r, snum_r};
						state_r <= ARSC_ST_REQ;
					end else if (cmd_wr && op48) begin
						busy_r <= 1'b1;
						ext_r <= 1'b1;
						chs_r <= 1'b0;
						remain_r <= ({scnt_p_r, scnt_r} == 16'h0000) ? `ARSC_CNT48_ZERO
							: {1'b0, scnt_p_r, scnt_r};
						addr_r <= {chi_p_r, clo_p_r, snum_p_r, chi_r, clo_r, snum_r};
						state_r <= ARSC_ST_REQ;
					end
				end
				ARSC_ST_REQ: begin
					start_r <= 1'b1;
					state_r <= ARSC_ST_XFER;
				end
				ARSC_ST_XFER: begin
					if (finish_err) begin
						busy_r <= 1'b0;
						state_r <= ARSC_ST_IDLE;
					end else if (finish_ok) begin
						remain_r <= 17'h00000;
						busy_r <= 1'b0;
						state_r <= ARSC_ST_IDLE;
					end else if (sect_end) begin
						// address stays on the last moved sector until more follow
						remain_r <= remain_r - 17'h00001;
						addr_r <= next_addr(addr_r, chs_r);
						state_r <= ARSC_ST_REQ;
					end
				end
				default: begin
					state_r <= ARSC_ST_IDLE;
					busy_r <= 1'b0;
				end
			endcase
		end
	end

	// data register and word count within the sector
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			data_r <= 16'h0000;
			drq_r <= 1'b0;
			word_r <= 8'h00;
		end else begin
			if (state_r == ARSC_ST_REQ) begin
				word_r <= 8'h00;
			end
			if (rsp_word) begin
				data_r <= media_rsp_i.data;
				drq_r <= 1'b1;
			end else if (data_rd) begin
				drq_r <= 1'b0;
				word_r <= word_r + 8'h01;
			end
		end
	end

	// error byte: cleared by a new command, set by media or a bad opcode
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			err_r <= 8'h00;
			err_flag_r <= 1'b0;
		end else if (cmd_wr) begin
			err_r <= 8'h00;
			err_r[`ARSC_ERR_ABT] <= cmd_abort;
			err_flag_r <= cmd_abort;
		end else if (finish_err) begin
			err_r[`ARSC_ERR_UNC] <= media_rsp_i.unc;
			err_r[`ARSC_ERR_IDN] <= media_rsp_i.idnf;
			err_flag_r <= 1'b1;
		end
	end

	// task-file bytes: host writes shift current into previous
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			scnt_r <= `ARSC_BYTE_RST;
			scnt_p_r <= 8'h00;
			snum_r <= `ARSC_BYTE_RST;
			snum_p_r <= 8'h00;
			clo_r <= 8'h00;
			clo_p_r <= 8'h00;
			chi_r <= 8'h00;
			chi_p_r <= 8'h00;
			devh_r <= `ARSC_DEVH_RST;
			hob_r <= 1'b0;
		end else if (wr_ok) begin
			case (reg_req_i.addr)
				`ARSC_OFF_SCNT: begin
					scnt_p_r <= scnt_r;
					scnt_r <= reg_req_i.wdata[7:0];
				end
				`ARSC_OFF_SNUM: begin
					snum_p_r <= snum_r;
					snum_r <= reg_req_i.wdata[7:0];
				end
				`ARSC_OFF_CLO: begin
					clo_p_r <= clo_r;
					clo_r <= reg_req_i.wdata[7:0];
				end
				`ARSC_OFF_CHI: begin
					chi_p_r <= chi_r;
					chi_r <= reg_req_i.wdata[7:0];
				end
				`ARSC_OFF_DEVH: devh_r <= reg_req_i.wdata[7:0];
				`ARSC_OFF_DCTL: hob_r <= reg_req_i.wdata[`ARSC_DCTL_HOB];
				default: begin
				end
			endcase
		end else if (finish_ok || finish_err) begin
			snum_r <= addr_r[7:0];
			clo_r <= addr_r[15:8];
			chi_r <= addr_r[23:16];
			if (ext_r) begin
				snum_p_r <= addr_r[31:24];
				clo_p_r <= addr_r[39:32];
				chi_p_r <= addr_r[47:40];
			end else begin
				devh_r[3:0] <= addr_r[27:24];
				scnt_r <= finish_ok ? 8'h00 : remain_r[7:0];
			end
		end
	end

	// interrupt status: set beats a write-one clear
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ists_r <= 3'h0;
			imsk_r <= 3'h0;
		end else begin
			if (reg_req_i.wr && reg_req_i.addr == `ARSC_OFF_IMSK) begin
				imsk_r <= reg_req_i.wdata[2:0];
			end
			ists_r[`ARSC_IRQ_DONE] <= finish_ok || finish_err || cmd_abort
				|| (ists_r[`ARSC_IRQ_DONE] && !(reg_req_i.wr
				&& reg_req_i.addr == `ARSC_OFF_ISTS && reg_req_i.wdata[`ARSC_IRQ_DONE]));
			ists_r[`ARSC_IRQ_ERR] <= finish_err || cmd_abort
				|| (ists_r[`ARSC_IRQ_ERR] && !(reg_req_i.wr
				&& reg_req_i.addr == `ARSC_OFF_ISTS && reg_req_i.wdata[`ARSC_IRQ_ERR]));
			ists_r[`ARSC_IRQ_DRQ] <= rsp_word
				|| (ists_r[`ARSC_IRQ_DRQ] && !(reg_req_i.wr
				&& reg_req_i.addr == `ARSC_OFF_ISTS && reg_req_i.wdata[`ARSC_IRQ_DRQ]));
		end
	end

	// status byte: BSY RDY DF DSC DRQ COR IDX ERR
	// ending status
	assign status = {busy_r && !drq_r, 1'b1, 1'b0, 1'b1, drq_r, 1'b0, 1'b0, err_flag_r};

	// read data one cycle after the read strobe
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_req_i.rd) begin
			case (reg_req_i.addr)
				`ARSC_OFF_DATA: reg_rdata_o <= data_r;
				`ARSC_OFF_SCNT: reg_rdata_o <= {8'h00, tf_sel(scnt_r, scnt_p_r, hob_r)};
				`ARSC_OFF_SNUM: reg_rdata_o <= {8'h00, tf_sel(snum_r, snum_p_r, hob_r)};
				`ARSC_OFF_CLO: reg_rdata_o <= {8'h00, tf_sel(clo_r, clo_p_r, hob_r)};
				`ARSC_OFF_CHI: reg_rdata_o <= {8'h00, tf_sel(chi_r, chi_p_r, hob_r)};
				`ARSC_OFF_DEVH: reg_rdata_o <= {8'h00, devh_r};
				`ARSC_OFF_CMD: reg_rdata_o <= {8'h00, status};
				`ARSC_OFF_ERR: reg_rdata_o <= {8'h00, err_r};
				`ARSC_OFF_DCTL: reg_rdata_o <= {8'h00, hob_r, 7'h00};
				`ARSC_OFF_ISTS: reg_rdata_o <= {13'h0000, ists_r};
				`ARSC_OFF_IMSK: reg_rdata_o <= {13'h0000, imsk_r};
				default: reg_rdata_o <= 16'h0000;
			endcase
		end
	end

	// media side: one start pulse per sector, words only while data reg empty
	assign media_req_o.start = start_r;
	assign media_req_o.chs = chs_r;
	assign media_req_o.addr = addr_r;
	assign media_rdy_o = (state_r == ARSC_ST_XFER) && !drq_r;
	assign busy_o = busy_r;
	assign irq_o = |(ists_r & imsk_r);
endmodule : arsc_read_cmd

// ==== tb/arsc_read_cmd_props.sv ====
// port checker for the read-sectors command block
`timescale 1ns/1ps
module arsc_read_cmd_props (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire arsc_pkg::arsc_reg_req_t reg_req_i,
	input wire logic [15:0] reg_rdata_o,
	input wire arsc_pkg::arsc_media_req_t media_req_o,
	input wire logic media_rdy_o,
	input wire arsc_pkg::arsc_media_rsp_t media_rsp_i,
	input wire logic busy_o,
	input wire logic irq_o
);
	import arsc_pkg::*;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	logic op_ok;
	// both read opcodes, retry bit ignored
	assign op_ok = reg_req_i.wdata[7:1] == 7'h10 || reg_req_i.wdata[7:0] == 8'h24;
	// command write taken while idle
	sequence s_cmd;
		reg_req_i.wr && reg_req_i.addr == 4'h7 && !busy_o;
	endsequence
	// media word or error taken
	sequence s_take;
		media_rdy_o && media_rsp_i.valid;
	endsequence
	a_cmd_starts: assert property (s_cmd ##0 op_ok |=> busy_o ##1 media_req_o.start)
		else $error("read command did not start");
	a_bad_op_idle: assert property (s_cmd ##0 !op_ok |=> !busy_o [*2])
		else $error("unknown opcode started a read");
	a_start_pulse: assert property (media_req_o.start |=> !media_req_o.start)
		else $error("sector start longer than one cycle");
	a_word_drops_rdy: assert property (s_take |=> !media_rdy_o)
		else $error("word ready held after a word");
	a_rdy_in_busy: assert property (media_rdy_o |-> busy_o)
		else $error("media ready while idle");
	a_unc_stops: assert property (s_take ##0 media_rsp_i.unc |=>
		!media_req_o.start throughout (##[0:8] !busy_o)) else $error("read went on after error");
	a_end_status: assert property (reg_req_i.rd && reg_req_i.addr == 4'h7 && !busy_o |=>
		reg_rdata_o[7:4] == 4'h5 && !reg_rdata_o[2]) else $error("bad idle status");
	a_err_bits: assert property (reg_req_i.rd && reg_req_i.addr == 4'h8 |=>
		(reg_rdata_o[7:0] & 8'hAB) == 8'h00) else $error("reserved error bit set");
	a_unmapped_zero: assert property (reg_req_i.rd && reg_req_i.addr > 4'hB |=>
		reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
	a_mask_off: assert property (reg_req_i.wr && reg_req_i.addr == 4'hB &&
		reg_req_i.wdata[2:0] == 3'h0 |=> !irq_o) else $error("irq with all masked");
endmodule : arsc_read_cmd_props
bind arsc_read_cmd arsc_read_cmd_props chk_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
	.reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .media_req_o(media_req_o),
	.media_rdy_o(media_rdy_o), .media_rsp_i(media_rsp_i), .busy_o(busy_o), .irq_o(irq_o));

// ==== tb/arsc_media_model.sv ====
// media side model: sector words and injected errors
`timescale 1ns/1ps
module arsc_media_model (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire arsc_pkg::arsc_media_req_t media_req_i,
	input wire logic media_rdy_i,
	input wire logic busy_i,
	input wire logic slow_i,
	input wire logic [7:0] err_at_i,
	output arsc_pkg::arsc_media_rsp_t media_rsp_o
);
	import arsc_pkg::*;
	logic act_r;
	logic tick_r;
	logic [8:0] widx_r;
	logic [7:0] nsec_r;
	logic [15:0] last_r;
	logic bad;
	assign bad = nsec_r == err_at_i;
	// words, every other cycle when slow; stale data never repeats
	assign media_rsp_o.valid = act_r && (!slow_i || tick_r);
	assign media_rsp_o.unc = media_rsp_o.valid && bad;
	assign media_rsp_o.idnf = 1'b0;
	assign media_rsp_o.data = media_rsp_o.valid ? media_req_i.addr[15:0] + {7'h00, widx_r} : ~last_r;
	// sector count and word index
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			act_r <= 1'b0;
			tick_r <= 1'b0;
			widx_r <= 9'h000;
			nsec_r <= 8'h00;
			last_r <= 16'h0000;
		end else begin
			tick_r <= !tick_r;
			if (!busy_i)
				nsec_r <= 8'h00;
			if (media_req_i.start) begin
				act_r <= 1'b1;
				widx_r <= 9'h000;
				nsec_r <= nsec_r + 8'h01;
			end else if (media_rsp_o.valid && media_rdy_i) begin
				last_r <= media_rsp_o.data;
				widx_r <= widx_r + 9'h001;
				act_r <= !bad && widx_r != 9'h0FF;
			end
		end
	end
endmodule : arsc_media_model

// ==== tb/arsc_read_cmd_test.sv ====
// self-checking bench for the read-sectors command block
`timescale 1ns/1ps
module arsc_read_cmd_test;
	import arsc_pkg::*;
	logic sys_clk_i;
	logic reset_i;
	logic slow;
	logic [7:0] err_at;
	logic [15:0] reg_rdata_o;
	logic media_rdy_o;
	logic busy_o;
	logic irq_o;
	arsc_reg_req_t reg_req_i;
	arsc_media_req_t media_req_o;
	arsc_media_rsp_t media_rsp_i;
	int error_cnt = 0;
	int num_checks = 0;
	arsc_read_cmd dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_req_i(reg_req_i),
		.reg_rdata_o(reg_rdata_o), .media_req_o(media_req_o), .media_rdy_o(media_rdy_o),
		.media_rsp_i(media_rsp_i), .busy_o(busy_o), .irq_o(irq_o));
	arsc_media_model med_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .media_req_i(media_req_o),
		.media_rdy_i(media_rdy_o), .busy_i(busy_o), .slow_i(slow), .err_at_i(err_at),
		.media_rsp_o(media_rsp_i));
	// 100 ns clock
	initial begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end
	task automatic chk(input string nm, input logic [48:0] e, input logic [48:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// a quiet cycle after each strobe, so no strobe is driven twice at one edge
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_req_i <= '{1'b1, 1'b0, a, d};
		@(posedge sys_clk_i);
		reg_req_i.wr <= 1'b0;
		@(posedge sys_clk_i);
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		reg_req_i <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge sys_clk_i);
		reg_req_i.rd <= 1'b0;
		@(posedge sys_clk_i);
		v = reg_rdata_o;
	endtask : rd
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		logic [15:0] v;
		rd(a, v);
		chk($sformatf("reg %h", a), {41'h0, e}, {41'h0, v[7:0]});
	endtask : rchk
	task automatic tf(input logic [7:0] sc, sn, cl, ch, dh);
		wr(4'h2, {8'h00, sc});
		wr(4'h3, {8'h00, sn});
		wr(4'h4, {8'h00, cl});
		wr(4'h5, {8'h00, ch});
		wr(4'h6, {8'h00, dh});
	endtask : tf
	// ending count, address, status and error
	task automatic fin(input logic [7:0] sc, sn, cl, ch, st, er);
		for (int k = 0; k < 200 && busy_o !== 1'b0; k++)
			@(posedge sys_clk_i);
		chk("busy", 49'h0, {48'h0, busy_o});
		rchk(4'h2, sc);
		rchk(4'h3, sn);
		rchk(4'h4, cl);
		rchk(4'h5, ch);
		rchk(4'h7, st);
		rchk(4'h8, er);
	endtask : fin
	// polls status for a word, then reads it
	task automatic sector(input logic [48:0] ma);
		logic [15:0] v;
		for (int w = 0; w < 256; w++) begin
			v = 16'h0000;
			for (int k = 0; k < 40 && v[3] !== 1'b1; k++)
				rd(4'h7, v);
			chk("drq", 49'h1, {48'h0, v[3]});
			if (w == 0)
				chk("media addr", ma, {media_req_o.chs, media_req_o.addr});
			rd(4'h0, v);
			chk("data word", {33'h0, ma[15:0] + w[15:0]}, {33'h0, v});
		end
	endtask : sector
	task automatic print_verdict;
		if (error_cnt == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	// hang guard, over ten times the expected run
	initial begin
		repeat (60000) @(posedge sys_clk_i);
		error_cnt++;
		print_verdict();
	end
	initial begin
		logic [15:0] v;
		reset_i = 1'b1;
		reg_req_i = '0;
		slow = 1'b0;
		err_at = 8'h00;
		repeat (12) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		@(posedge sys_clk_i);
		rchk(4'h2, 8'h01);
		rchk(4'h6, 8'hA0);
		rchk(4'hC, 8'h00);
		// lba, retry opcode, one sector
		tf(8'h01, 8'hEF, 8'hCD, 8'hAB, 8'hE5);
		wr(4'h7, 16'h0021);
		sector({1'b0, 48'h0000_05AB_CDEF});
		fin(8'h00, 8'hEF, 8'hCD, 8'hAB, 8'h50, 8'h00);
		rd(4'h6, v);
		chk("head", {45'h0, 4'h5}, {45'h0, v[3:0]});
		// chs, count zero, slow media, second sector fails
		slow <= 1'b1;
		err_at <= 8'h02;
		tf(8'h00, 8'h05, 8'h34, 8'h12, 8'hA3);
		wr(4'h7, 16'h0020);
		sector({1'b1, 48'h0000_0312_3405});
		fin(8'hFF, 8'h06, 8'h34, 8'h12, 8'h51, 8'h40);
		rd(4'h6, v);
		chk("head", {45'h0, 4'h3}, {45'h0, v[3:0]});
		slow <= 1'b0;
		err_at <= 8'h00;
		// sticky irq, mask, write-one-clear
		rchk(4'hA, 8'h07);
		wr(4'hB, 16'h0002);
		chk("irq", 49'h1, {48'h0, irq_o});
		wr(4'hA, 16'h0002);
		chk("irq", 49'h0, {48'h0, irq_o});
		wr(4'hB, 16'h0000);
		wr(4'hA, 16'h0007);
		// unknown opcode is aborted
		wr(4'h7, 16'h00EC);
		// an aborted command leaves the earlier ending count in place
		fin(8'hFF, 8'h06, 8'h34, 8'h12, 8'h51, 8'h04);
		// 48-bit: previous bytes then current bytes
		tf(8'h00, 8'h44, 8'h55, 8'h66, 8'hE0);
		tf(8'h01, 8'h11, 8'h22, 8'h33, 8'hE0);
		wr(4'h7, 16'h0024);
		sector({1'b0, 48'h6655_4433_2211});
		fin(8'h01, 8'h11, 8'h22, 8'h33, 8'h50, 8'h00);
		wr(4'h9, 16'h0080);
		rchk(4'h3, 8'h44);
		rchk(4'h4, 8'h55);
		rchk(4'h5, 8'h66);
		print_verdict();
	end
endmodule : arsc_read_cmd_test
